/* logic/cmfs_top.sv */
/*
  Transmit mailbox and receive queue status registers with a masked interrupt.
  Assumes a protocol engine that pulses transmit and receive events for one cycle
  and a software master on a word-wide register port with a one-cycle read.
*/
// Decided for this implementation: the plain strobed port.
// Contract
// - Done flag sets on finish or abort
// - Success flag sets on clean finish
// - Error flag sets on transmit error
// - Arbitration-lost flag sets on lost arbitration
// - Abort request held until mailbox empty
// - Release request cleared once dequeue done
// - Overflow flag sets on store while full; the code skips it when a release completes in that same cycle
// - Full flag sets when queue fills
// - Two-bit frame count per queue
// - Queue registers at 0x0C, 0x10, reset zero
`timescale 1ns/1ps
module cmfs_top
  import cmfs_pkg::*;
#(
  parameter int DEPTH = RXQ_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic [NUM_MB-1:0] i_tx_request_set,
  input wire logic [NUM_MB-1:0] i_tx_start,
  input wire logic [NUM_MB-1:0] i_tx_ok,
  input wire logic [NUM_MB-1:0] i_tx_fail,
  input wire logic [NUM_MB-1:0] i_tx_aborted,
  input wire logic [NUM_MB-1:0] i_tx_error,
  input wire logic [NUM_MB-1:0] i_arb_lost,
  input wire logic [NUM_MB-1:0] i_mb_empty,
  output logic [NUM_MB-1:0] o_abort_request,
  input wire logic [NUM_RXQ-1:0] i_rx_store,
  input wire logic [NUM_RXQ-1:0] i_release_done,
  output logic [NUM_RXQ-1:0] o_release_request,
  output logic [NUM_RXQ-1:0] o_rxq_full,
  output logic o_irq
);
  initial begin
    if (DEPTH < 1 || DEPTH > 3) begin
      $error("cmfs_top: DEPTH must lie in 1..3");
    end
  end

  cmfs_top_st_t st;
  cmfs_top_st_t next_st;

  logic wr_tx;
  logic wr_irq_st;
  logic wr_irq_mask;
  logic [NUM_RXQ-1:0] wr_rxq;
  logic [CNT_W-1:0] q_count [NUM_RXQ];
  logic [NUM_RXQ-1:0] q_full;
  logic [NUM_RXQ-1:0] q_ovf;
  logic [NUM_RXQ-1:0] q_full_evt;
  logic [NUM_RXQ-1:0] q_ovf_evt;
  logic [NUM_MB-1:0] tx_fin;
  logic [IRQ_W-1:0] irq_evt;
  logic [DATA_W-1:0] tx_word;
  logic [DATA_W-1:0] q_word [NUM_RXQ];

  // Whole-word decode only; the port has no byte lanes to misuse
  assign wr_tx = i_wr && (i_addr == OFF_TX_STATUS);
  assign wr_rxq[0] = i_wr && (i_addr == OFF_RXQ0_STATUS);
  assign wr_rxq[1] = i_wr && (i_addr == OFF_RXQ1_STATUS);
  assign wr_irq_st = i_wr && (i_addr == OFF_IRQ_STATUS);
  assign wr_irq_mask = i_wr && (i_addr == OFF_IRQ_MASK);

  assign tx_fin = i_tx_ok | i_tx_fail | i_tx_aborted;

  for (genvar q = 0; q < NUM_RXQ; q++) begin : g_rxq
    cmfs_rxq #(
      .DEPTH(DEPTH)
    ) u_rxq (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_store(i_rx_store[q]),
      .i_done(i_release_done[q]),
      .i_set_release(wr_rxq[q] && i_wdata[RXQ_REL_BIT]),
      .i_clr_full(wr_rxq[q] && i_wdata[RXQ_FULL_BIT]),
      .i_clr_ovf(wr_rxq[q] && i_wdata[RXQ_OVF_BIT]),
      .o_count(q_count[q]),
      .o_full(q_full[q]),
      .o_ovf(q_ovf[q]),
      .o_release(o_release_request[q]),
      .o_full_evt(q_full_evt[q]),
      .o_ovf_evt(q_ovf_evt[q])
    );
    always_comb begin
      q_word[q] = RST_WORD;
      q_word[q][RXQ_CNT_LSB +: CNT_W] = q_count[q];
      q_word[q][RXQ_FULL_BIT] = q_full[q];
      q_word[q][RXQ_OVF_BIT] = q_ovf[q];
      q_word[q][RXQ_REL_BIT] = o_release_request[q];
    end
  end

  assign o_rxq_full = q_full;

  always_comb begin
    tx_word = RST_WORD;
    for (int m = 0; m < NUM_MB; m++) begin
      tx_word[m * MB_STRIDE + TX_DONE_BIT] = st.done[m];
      tx_word[m * MB_STRIDE + TX_SUCC_BIT] = st.succ[m];
      tx_word[m * MB_STRIDE + TX_ARB_BIT] = st.arb[m];
      tx_word[m * MB_STRIDE + TX_ERR_BIT] = st.err[m];
      tx_word[m * MB_STRIDE + TX_ABORT_BIT] = st.abort[m];
    end
  end

  always_comb begin
    irq_evt = RST_IRQ;
    irq_evt[IRQ_MB0_DONE] = tx_fin[0];
    irq_evt[IRQ_MB1_DONE] = tx_fin[1];
    irq_evt[IRQ_Q0_FULL] = q_full_evt[0];
    irq_evt[IRQ_Q0_OVF] = q_ovf_evt[0];
    irq_evt[IRQ_Q1_FULL] = q_full_evt[1];
    irq_evt[IRQ_Q1_OVF] = q_ovf_evt[1];
  end

  always_comb begin
    next_st = st;
    for (int m = 0; m < NUM_MB; m++) begin
      // Software clears first; any hardware event below overrides them
      if (wr_tx && i_wdata[m * MB_STRIDE + TX_DONE_BIT]) begin
        next_st.done[m] = 1'b0;
        next_st.succ[m] = 1'b0;
        next_st.arb[m] = 1'b0;
        next_st.err[m] = 1'b0;
      end
      if (wr_tx && i_wdata[m * MB_STRIDE + TX_SUCC_BIT]) begin
        next_st.succ[m] = 1'b0;
      end
      if (wr_tx && i_wdata[m * MB_STRIDE + TX_ARB_BIT]) begin
        next_st.arb[m] = 1'b0;
      end
      if (wr_tx && i_wdata[m * MB_STRIDE + TX_ERR_BIT]) begin
        next_st.err[m] = 1'b0;
      end
      if (i_tx_request_set[m]) begin
        next_st.done[m] = 1'b0;
      end
      if (i_tx_start[m]) begin
        next_st.err[m] = 1'b0;
        next_st.arb[m] = 1'b0;
      end
      if (i_mb_empty[m]) begin
        next_st.abort[m] = 1'b0;
      end
      if (wr_tx && i_wdata[m * MB_STRIDE + TX_ABORT_BIT]) begin
        next_st.abort[m] = 1'b1;
      end
      if (i_tx_error[m]) begin
        next_st.err[m] = 1'b1;
      end
      if (i_arb_lost[m]) begin
        next_st.arb[m] = 1'b1;
      end
      if (i_tx_ok[m]) begin
        next_st.succ[m] = 1'b1;
      end
      if (i_tx_fail[m]) begin
        next_st.succ[m] = 1'b0;
      end
      if (tx_fin[m]) begin
        next_st.done[m] = 1'b1;
      end
    end

    if (wr_irq_st) begin
      next_st.irq_st = st.irq_st & ~i_wdata[IRQ_W-1:0];
    end
    next_st.irq_st = next_st.irq_st | irq_evt;
    if (wr_irq_mask) begin
      next_st.irq_mask = i_wdata[IRQ_W-1:0];
    end

    // Read data live for one cycle only; zero otherwise and for unmapped offsets
    next_st.rdata = RST_WORD;
    if (i_rd) begin
      case (i_addr)
        OFF_TX_STATUS: next_st.rdata = tx_word;
        OFF_RXQ0_STATUS: next_st.rdata = q_word[0];
        OFF_RXQ1_STATUS: next_st.rdata = q_word[1];
        OFF_IRQ_STATUS: next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st.irq_st};
        OFF_IRQ_MASK: next_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st.irq_mask};
        default: next_st.rdata = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_abort_request = st.abort;
  assign o_irq = |(st.irq_st & st.irq_mask);

  chk_done_ok: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_tx_ok[0] && !i_tx_fail[0]) |=> (st.done[0] && st.succ[0]))
    else $error("clean finish did not set done and success");
  chk_fail_succ: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_tx_fail[1]) |=> (st.done[1] && !st.succ[1]))
    else $error("failed finish left success set");
  chk_start_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_tx_start[0] && !i_tx_error[0] && !i_arb_lost[0]) |=> (!st.err[0] && !st.arb[0]))
    else $error("start did not clear error and arbitration flags");
  chk_arb_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_arb_lost[1]) |=> st.arb[1])
    else $error("arbitration loss not flagged");
  chk_abort_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (st.abort[0] && !i_mb_empty[0]) |=> st.abort[0])
    else $error("abort request dropped before mailbox empty");
  chk_abort_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_mb_empty[0] && !(wr_tx && i_wdata[TX_ABORT_BIT])) |=> !st.abort[0])
    else $error("abort request kept with mailbox empty");
  chk_zero_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_tx && i_wdata == RST_WORD && st.done[0] && !i_tx_request_set[0]) |=> st.done[0])
    else $error("zero write cleared a flag");
  chk_rdata_slot: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !i_rd) |=> (o_rdata == RST_WORD))
    else $error("read data outside its cycle");
  chk_rxq_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_rd && i_addr == OFF_RXQ0_STATUS) |=> (o_rdata[CNT_W-1:0] == $past(q_count[0])))
    else $error("frame count misreported");
  chk_irq_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && tx_fin[0] && st.irq_mask[IRQ_MB0_DONE] && !wr_irq_mask) |=> o_irq)
    else $error("unmasked event gave no interrupt");

  // Clears from software or a new transfer; a same-cycle hardware set wins
  chk_done_request: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_tx_request_set[0] && !tx_fin[0]) |=> !st.done[0])
    else $error("transmit request left done flag set");
  chk_done_w1c: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_tx && i_wdata[MB_STRIDE + TX_DONE_BIT] && !tx_fin[1] && !i_tx_error[1] &&
      !i_arb_lost[1]) |=> !(st.done[1] || st.succ[1] || st.arb[1] || st.err[1]))
    else $error("done write did not clear the mailbox flags");
  chk_succ_w1c: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_tx && i_wdata[TX_SUCC_BIT] && !i_tx_ok[0]) |=> !st.succ[0])
    else $error("success flag kept after a clear");
  chk_err_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_tx_error[1]) |=> st.err[1])
    else $error("transmit error not flagged");
  chk_err_w1c: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_tx && i_wdata[MB_STRIDE + TX_ERR_BIT] && !i_tx_error[1]) |=> !st.err[1])
    else $error("error flag kept after a clear");
  chk_arb_w1c: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_tx && i_wdata[TX_ARB_BIT] && !i_arb_lost[0]) |=> !st.arb[0])
    else $error("arbitration flag kept after a clear");
  chk_abort_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_tx && i_wdata[MB_STRIDE + TX_ABORT_BIT]) |=> st.abort[1])
    else $error("abort write did not set the request");
  chk_abort_source: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !st.abort[0] && !(wr_tx && i_wdata[TX_ABORT_BIT])) |=> !st.abort[0])
    else $error("abort request rose without a write");

  // A low enable must hold every flag and the read data
  chk_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_ce |=> ($stable(st) && $stable(q_word[0]) && $stable(q_word[1])))
    else $error("state moved while the enable was low");
  chk_irq_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_irq_st && i_wdata[IRQ_W-1:0] == {IRQ_W{1'b1}} && irq_evt == RST_IRQ) |=>
      (st.irq_st == RST_IRQ && !o_irq))
    else $error("interrupt status kept after a full clear");
  chk_mask_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_irq_mask) |=> (st.irq_mask == $past(i_wdata[IRQ_W-1:0])))
    else $error("mask write not taken");

  // Read path fields of the queue words
  chk_q1_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_rd && i_addr == OFF_RXQ1_STATUS) |=> (o_rdata[CNT_W-1:0] == $past(q_count[1])
      && o_rdata[RXQ_REL_BIT] == $past(o_release_request[1])))
    else $error("second queue word misreported");
  chk_q0_flags: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_rd && i_addr == OFF_RXQ0_STATUS) |=> (o_rdata[RXQ_FULL_BIT] == $past(q_full[0])
      && o_rdata[RXQ_OVF_BIT] == $past(q_ovf[0])))
    else $error("queue flags misreported");
  chk_zero_queue: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && wr_rxq[0] && i_wdata == RST_WORD && q_full[0]) |=> q_full[0])
    else $error("zero write cleared the full flag");

  cov_tx_done: cover property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_tx_ok[0] ##1 wr_tx);
  cov_abort: cover property (@(posedge i_clk) disable iff (!i_resetn)
    st.abort[1] ##[1:20] !st.abort[1]);
  cov_release: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_release_request[0] ##[1:20] !o_release_request[0]);
  cov_irq: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_irq));
endmodule

/* logic/cmfs_pkg.sv */
/*
  Shared constants and state types of the CAN mailbox and receive queue status block.
  Assumes a word-wide register port with byte offsets and one peripheral clock.
*/
package cmfs_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int NUM_MB = 2;
  localparam int NUM_RXQ = 2;
  localparam int RXQ_DEPTH = 3;
  localparam int CNT_W = 2;
  localparam int IRQ_W = 6;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TX_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RXQ0_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_RXQ1_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h24;

  // Mailbox status fields, mailbox n starts at bit n * MB_STRIDE
  localparam int MB_STRIDE = 8;
  localparam int TX_DONE_BIT = 0;
  localparam int TX_SUCC_BIT = 1;
  localparam int TX_ARB_BIT = 2;
  localparam int TX_ERR_BIT = 3;
  localparam int TX_ABORT_BIT = 7;

  // Receive queue status fields
  localparam int RXQ_CNT_LSB = 0;
  localparam int RXQ_FULL_BIT = 3;
  localparam int RXQ_OVF_BIT = 4;
  localparam int RXQ_REL_BIT = 5;

  // Interrupt status and mask fields
  localparam int IRQ_MB0_DONE = 0;
  localparam int IRQ_MB1_DONE = 1;
  localparam int IRQ_Q0_FULL = 2;
  localparam int IRQ_Q0_OVF = 3;
  localparam int IRQ_Q1_FULL = 4;
  localparam int IRQ_Q1_OVF = 5;

  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 6'h00;
  localparam logic [NUM_MB-1:0] RST_MB = 2'h0;
  localparam logic [CNT_W-1:0] RST_CNT = 2'h0;

  typedef struct packed {
    logic [NUM_MB-1:0] done;
    logic [NUM_MB-1:0] succ;
    logic [NUM_MB-1:0] arb;
    logic [NUM_MB-1:0] err;
    logic [NUM_MB-1:0] abort;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
  } cmfs_top_st_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic full;
    logic ovf;
    logic release_req;
  } cmfs_rxq_st_t;
endpackage

/* logic/cmfs_rxq.sv */
/*
  One receive queue status slice: frame count, full and overfull flags, release request.
  Assumes single-cycle store and release-done pulses from the protocol engine.
*/
`timescale 1ns/1ps
module cmfs_rxq
  import cmfs_pkg::*;
#(
  parameter int DEPTH = RXQ_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_store,
  input wire logic i_done,
  input wire logic i_set_release,
  input wire logic i_clr_full,
  input wire logic i_clr_ovf,
  output logic [CNT_W-1:0] o_count,
  output logic o_full,
  output logic o_ovf,
  output logic o_release,
  output logic o_full_evt,
  output logic o_ovf_evt
);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

  initial begin
    if (DEPTH < 1 || DEPTH > 3) begin
      $error("cmfs_rxq: DEPTH must lie in 1..3");
    end
  end

  cmfs_rxq_st_t st;
  cmfs_rxq_st_t next_st;
  logic stored;
  logic released;

  // A frame is dropped, not stored, when the queue is already full
  assign stored = i_store && (st.count != DEPTH_C);
  // Release only completes against a held frame
  assign released = i_done && st.release_req && (st.count != RST_CNT);
  assign o_ovf_evt = i_store && (st.count == DEPTH_C) && !released;
  assign o_full_evt = stored && !released && (st.count == DEPTH_C - 2'h1);

  always_comb begin
    next_st = st;
    if (stored && !released) begin
      next_st.count = st.count + 2'h1;
    end else if (released && !stored) begin
      next_st.count = st.count - 2'h1;
    end
    // Clear first, so a same-cycle event still sets the flag
    if (i_clr_full) begin
      next_st.full = 1'b0;
    end
    if (i_clr_ovf) begin
      next_st.ovf = 1'b0;
    end
    if (o_full_evt) begin
      next_st.full = 1'b1;
    end
    if (o_ovf_evt) begin
      next_st.ovf = 1'b1;
    end
    if (released) begin
      next_st.release_req = 1'b0;
    end
    if (i_set_release && st.count != RST_CNT) begin
      next_st.release_req = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_count = st.count;
  assign o_full = st.full;
  assign o_ovf = st.ovf;
  assign o_release = st.release_req;

  chk_ovf_on_full: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_store && st.count == DEPTH_C && !i_done) |=> (st.ovf && st.count == DEPTH_C))
    else $error("overflow not flagged or count moved on a full store");
  chk_empty_release: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && st.count == RST_CNT && !st.release_req) |=> (!st.release_req && st.count <= 2'h1))
    else $error("release taken with an empty queue");
  chk_full_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (st.full && !i_clr_full) |=> st.full)
    else $error("full flag dropped without a clear");
  chk_release_done: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ce && released && !i_set_release && !i_store) |=> (!st.release_req &&
      st.count == $past(st.count) - 2'h1))
    else $error("release not finished or count not lowered");
  cov_overflow: cover property (@(posedge i_clk) disable iff (!i_resetn) o_ovf_evt && i_ce);
endmodule

/* bench/cmfs_engine_model.sv */
/*
  Behavioural protocol engine standing behind the status block: answers dequeue
  requests after a short or long pause and empties a loaded mailbox on abort.
  Assumes one clock and an active-low asynchronous reset shared with the block.
*/
`timescale 1ns/1ps
module cmfs_engine_model
  import cmfs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_slow,
  input wire logic [NUM_MB-1:0] i_load,
  input wire logic [NUM_MB-1:0] i_abort_request,
  input wire logic [NUM_RXQ-1:0] i_release_request,
  output logic [NUM_MB-1:0] o_mb_empty,
  output logic [NUM_MB-1:0] o_tx_aborted,
  output logic [NUM_RXQ-1:0] o_release_done
);
  int q_wait [NUM_RXQ];
  int m_wait [NUM_MB];

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mb_empty <= 2'h3;
      o_tx_aborted <= 2'h0;
      o_release_done <= 2'h0;
      q_wait <= '{default: 0};
      m_wait <= '{default: 0};
    end else begin
      for (int n = 0; n < NUM_RXQ; n++) begin
        o_release_done[n] <= 1'b0;
        // One done pulse per request; guard skips the cycle it is still seen
        if (i_release_request[n] && !o_release_done[n]) begin
          if (q_wait[n] >= (i_slow ? 6 : 0)) begin
            o_release_done[n] <= 1'b1;
            q_wait[n] <= 0;
          end else begin
            q_wait[n] <= q_wait[n] + 1;
          end
        end
      end
      for (int n = 0; n < NUM_MB; n++) begin
        o_tx_aborted[n] <= 1'b0;
        if (i_load[n]) begin
          o_mb_empty[n] <= 1'b0;
        end else if (i_abort_request[n] && !o_mb_empty[n]) begin
          // Abort takes a few cycles, so the request must be held
          if (m_wait[n] >= 4) begin
            o_tx_aborted[n] <= 1'b1;
            o_mb_empty[n] <= 1'b1;
            m_wait[n] <= 0;
          end else begin
            m_wait[n] <= m_wait[n] + 1;
          end
        end
      end
    end
  end
endmodule

/* bench/cmfs_top_bench.sv */
/*
  Self-checking bench of the mailbox and receive queue status block.
  Assumes the engine model file is compiled first; one 50 MHz clock.
*/
`timescale 1ns/1ps
module cmfs_top_bench;
  import cmfs_pkg::*;
  logic clk, rstn, ce, wr, rd, slow, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [NUM_MB-1:0] req_set, start, ok, fl, err, arb, abort_req, empty, aborted;
  logic [NUM_RXQ-1:0] store, rel_done, rel_req, full;
  int fail_count, n_compared;

  cmfs_top u_dut (.i_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_request_set(req_set),
    .i_tx_start(start), .i_tx_ok(ok), .i_tx_fail(fl), .i_tx_aborted(aborted),
    .i_tx_error(err), .i_arb_lost(arb), .i_mb_empty(empty), .o_abort_request(abort_req),
    .i_rx_store(store), .i_release_done(rel_done), .o_release_request(rel_req),
    .o_rxq_full(full), .o_irq(irq));

  cmfs_engine_model u_engine (.i_clk(clk), .i_resetn(rstn), .i_slow(slow),
    .i_load(req_set), .i_abort_request(abort_req), .i_release_request(rel_req),
    .o_mb_empty(empty), .o_tx_aborted(aborted), .o_release_done(rel_done));

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
      input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Whole 32-bit words only; the port has no byte lanes
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
      input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask

  task automatic ev(input int k, input logic [1:0] m);
    @(posedge clk);
    case (k)
      0: req_set <= m;
      1: start <= m;
      2: ok <= m;
      3: fl <= m;
      4: err <= m;
      5: arb <= m;
      default: store <= m;
    endcase
    @(posedge clk);
    {req_set, start, ok, fl, err, arb, store} <= '0;
  endtask

  task automatic t_reset;
    rchk(OFF_RXQ0_STATUS, RST_WORD, "q0 reset");
    rchk(OFF_RXQ1_STATUS, RST_WORD, "q1 reset");
    rchk(8'h04, 32'h0000_0000, "unmapped");
    rchk(OFF_TX_STATUS, RST_WORD, "tx reset");
  endtask

  task automatic t_tx;
    ev(2, 2'h1);
    rchk(OFF_TX_STATUS, 32'h0000_0003, "done succ");
    wr_reg(OFF_TX_STATUS, 32'h0000_0000);
    rchk(OFF_TX_STATUS, 32'h0000_0003, "zero write");
    wr_reg(OFF_TX_STATUS, 32'h0000_0001);
    rchk(OFF_TX_STATUS, 32'h0000_0000, "done w1c");
    ev(2, 2'h1);
    ev(4, 2'h1);
    ev(5, 2'h1);
    ev(3, 2'h1);
    rchk(OFF_TX_STATUS, 32'h0000_000D, "fail err arb");
    wr_reg(OFF_TX_STATUS, 32'h0000_0004);
    rchk(OFF_TX_STATUS, 32'h0000_0009, "arb w1c");
    ev(1, 2'h1);
    rchk(OFF_TX_STATUS, 32'h0000_0001, "start clears");
    ev(0, 2'h1);
    rchk(OFF_TX_STATUS, 32'h0000_0000, "request clears");
    ev(2, 2'h2);
    wr_reg(OFF_TX_STATUS, 32'h0000_0200);
    rchk(OFF_TX_STATUS, 32'h0000_0100, "succ w1c");
  endtask

  task automatic t_abort;
    int i;
    ev(0, 2'h2);
    rchk(OFF_TX_STATUS, 32'h0000_0000, "mb1 request");
    wr_reg(OFF_TX_STATUS, 32'h0000_8000);
    repeat (2) @(posedge clk);
    #1;
    chk(DATA_W'(abort_req), 32'h0000_0002, "abort held");
    for (i = 0; i < 20 && abort_req[1]; i++) @(posedge clk);
    #1;
    chk(DATA_W'(i < 20), 32'h0000_0001, "abort wait");
    chk(DATA_W'(abort_req), 32'h0000_0000, "abort cleared");
    rchk(OFF_TX_STATUS, 32'h0000_0100, "abort done");
  endtask

  task automatic t_rx;
    int i;
    wr_reg(OFF_IRQ_MASK, 32'h0000_0004);
    #1;
    chk(DATA_W'(irq), 32'h0000_0000, "done masked");
    rchk(OFF_IRQ_MASK, 32'h0000_0004, "mask read");
    ev(6, 2'h1);
    ev(6, 2'h1);
    rchk(OFF_RXQ0_STATUS, 32'h0000_0002, "count 2");
    ev(6, 2'h1);
    rchk(OFF_RXQ0_STATUS, 32'h0000_000B, "full");
    chk(DATA_W'({full, irq}), 32'h0000_0003, "full irq");
    ev(6, 2'h1);
    rchk(OFF_RXQ0_STATUS, 32'h0000_001B, "overflow");
    rchk(OFF_IRQ_STATUS, 32'h0000_000F, "irq status");
    wr_reg(OFF_IRQ_STATUS, 32'h0000_003F);
    repeat (2) @(posedge clk);
    #1;
    chk(DATA_W'(irq), 32'h0000_0000, "irq cleared");
    wr_reg(OFF_RXQ0_STATUS, 32'h0000_0018);
    slow <= 1'b1;
    rchk(OFF_RXQ0_STATUS, 32'h0000_0003, "flags w1c");
    wr_reg(OFF_RXQ0_STATUS, 32'h0000_0020);
    #1;
    chk(DATA_W'(rel_req), 32'h0000_0001, "release set");
    for (i = 0; i < 30 && rel_req[0]; i++) @(posedge clk);
    chk(DATA_W'(i < 30), 32'h0000_0001, "slow wait");
    rchk(OFF_RXQ0_STATUS, 32'h0000_0002, "slow release");
    wr_reg(OFF_RXQ1_STATUS, 32'h0000_0020);
    #1;
    chk(DATA_W'(rel_req), 32'h0000_0000, "empty refused");
    rchk(OFF_RXQ1_STATUS, 32'h0000_0000, "empty count");
    ev(6, 2'h2);
    slow <= 1'b0;
    wr_reg(OFF_RXQ1_STATUS, 32'h0000_0020);
    #1;
    chk(DATA_W'(rel_req), 32'h0000_0002, "q1 release set");
    for (i = 0; i < 30 && rel_req[1]; i++) @(posedge clk);
    chk(DATA_W'(i < 30), 32'h0000_0001, "fast wait");
    rchk(OFF_RXQ1_STATUS, 32'h0000_0000, "fast release");
  endtask

  // A store while the enable is low must leave the count alone
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    ev(6, 2'h1);
    ce <= 1'b1;
    rchk(OFF_RXQ0_STATUS, 32'h0000_0002, "frozen store");
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t run timed out", $time);
    wrap_up;
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    slow = 1'b0;
    addr = '0;
    wdata = '0;
    {req_set, start, ok, fl, err, arb, store} = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_tx;
    t_abort;
    t_rx;
    t_freeze;
    wrap_up;
  end
endmodule
